// ==== hdl/cmp_edge_params.svh ====
`ifndef CMP_EDGE_PARAMS_SVH
`define CMP_EDGE_PARAMS_SVH
// Register indices; some offsets are not word multiples, so bus address is index * 4
`define REG_IDX_COMPARATOR_CONTROL   12'h1F8
`define REG_IDX_INPUT_REQUEST_ENABLE 12'h1FA
`define REG_IDX_INPUT_FILTER_SELECT  12'h1FC
`define REG_IDX_IRQ_CONTROL_SRC1     12'h200
`define REG_IDX_IRQ_CONTROL_SRC3     12'h201
`define REG_IDX_IRQ_STATUS           12'h202
`define REG_IDX_IRQ_MASK             12'h203
// Field positions
`define CHAN1_OPERATE_BIT  0
`define CHAN1_RESULT_BIT   3
`define CHAN3_OPERATE_BIT  4
`define CHAN3_RESULT_BIT   7
`define SRC0_REQ_ON_BIT    0
`define SRC0_EDGE_MODE_BIT 1
`define SRC1_REQ_ON_BIT    2
`define SRC1_EDGE_MODE_BIT 3
`define SRC3_REQ_ON_BIT    6
`define SRC3_EDGE_MODE_BIT 7
`define SRC0_FILTER_LSB    0
`define SRC1_FILTER_LSB    2
`define SRC3_FILTER_LSB    6
`define IRQC_LEVEL_LSB     0
`define IRQC_PENDING_BIT   3
`define IRQC_DIRECTION_BIT 4
// Reset values
`define REG_RESET_VALUE    8'h00
// Timing
`define DIV_EIGHT_COUNT    3'd7
`define DIV_THIRTYTWO_COUNT 5'd31
`define FILTER_AGREE_COUNT 2'd3
`endif

// ==== hdl/cmp_edge_pkg.sv ====
`default_nettype none
package cmp_edge_pkg;
    typedef enum logic [1:0]
    {
        FILT_NONE,
        FILT_F1,
        FILT_F8,
        FILT_F32
    } filter_sel_t;
    typedef logic [7:0] reg8_t;
endpackage
`default_nettype wire

// ==== hdl/cmp_edge_channel.sv ====
`include "cmp_edge_params.svh"
`default_nettype none
module cmp_edge_channel
(
    input  wire logic               clk_sys_in,
    input  wire logic               sys_rst_in,
    input  wire logic               operate_in,
    input  wire logic               raw_result_in,
    input  wire cmp_edge_pkg::filter_sel_t filter_in,
    input  wire logic               tick_f8_in,
    input  wire logic               tick_f32_in,
    input  wire logic               request_on_in,
    input  wire logic               both_edges_in,
    input  wire logic               direction_in,
    output logic                    result_out,
    output logic                    edge_out
);
    import cmp_edge_pkg::*;

    logic       sync_a;
    logic       sync_b;
    logic [1:0] agree;
    logic       cand;
    logic       level;
    logic       level_q;
    logic       next_sync_a;
    logic       next_sync_b;
    logic [1:0] next_agree;
    logic       next_cand;
    logic       next_level;
    logic       next_level_q;
    logic       tick;
    logic       src_level;
    logic       rise;
    logic       fall;

    always_comb
    begin
        next_sync_a = raw_result_in;
        next_sync_b = sync_a;
        // Disabled comparator reads 0
        src_level = sync_b & operate_in;
        case (filter_in)
            FILT_F1:  tick = 1'b1;
            FILT_F8:  tick = tick_f8_in;
            FILT_F32: tick = tick_f32_in;
            default:  tick = 1'b0;
        endcase
        next_agree = agree;
        next_cand = cand;
        next_level = level;
        if (filter_in == FILT_NONE)
        begin
            next_level = src_level; // R15
            next_cand = src_level;
            next_agree = 2'd0;
        end
        else if (tick)
        begin
            // Three agreeing samples qualify a new level
            if (src_level != cand)
            begin
                next_cand = src_level;
                next_agree = 2'd1;
            end
            else if (agree != `FILTER_AGREE_COUNT)
            begin
                next_agree = agree + 2'd1;
            end
            if ((src_level == cand) && (agree == 2'd2))
            begin
                next_level = cand; // R11
            end
        end
        next_level_q = level;
        rise = level & ~level_q;
        fall = ~level & level_q;
        // Single edge follows the direction bit; both edges ignore it
        edge_out = request_on_in &
            (both_edges_in ? (rise | fall) : (direction_in ? rise : fall)); // R10
        result_out = src_level; // R2
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
        begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            agree <= 2'd0;
            cand <= 1'b0;
            level <= 1'b0;
            level_q <= 1'b0;
        end
        else
        begin
            sync_a <= next_sync_a;
            sync_b <= next_sync_b;
            agree <= next_agree;
            cand <= next_cand;
            level <= next_level;
            level_q <= next_level_q;
        end
    end

    property p_unfiltered_follow;
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        (filter_in == FILT_NONE) && $stable(filter_in) |=> (level == $past(src_level));
    endproperty
    a_unfiltered_follow: assert property (p_unfiltered_follow) // R15
        else $error("unfiltered level does not follow result");

    property p_no_edge_when_off;
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        !request_on_in |-> !edge_out;
    endproperty
    a_no_edge_when_off: assert property (p_no_edge_when_off) // R10
        else $error("edge raised while request disabled");

    property p_f1_three_samples;
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        // The whole sample window must be F1; bypass mode moves the level at once
        $changed(level) && ($past(filter_in, 1) == FILT_F1) && ($past(filter_in, 2) == FILT_F1)
            && ($past(filter_in, 3) == FILT_F1) |-> ($past(src_level, 1) == level)
            && ($past(src_level, 2) == level) && ($past(src_level, 3) == level);
    endproperty
    a_f1_three_samples: assert property (p_f1_three_samples) // R11
        else $error("filtered level changed without three agreeing samples");

    property p_result_zero_disabled;
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        !operate_in |-> !result_out;
    endproperty
    a_result_zero_disabled: assert property (p_result_zero_disabled) // R2
        else $error("result set while channel disabled");
endmodule
`default_nettype wire

// ==== hdl/dual_comparator_edge_irq.sv ====
// Functional notes
// R1: Per-channel operate enable at bits 0, 4
// R2: Result flag 1 when input above reference
// R3: Per-source request enable bits 0, 2, 6
// R4: Edge mode bits: 0 single, 1 both
// R5: Software clears direction before selecting both edges
// R6: Request enable write may set pending flag
// R7: Filter code: none, f1, f8, f32
// R8: Filter fields at 0-1, 2-3, 6-7
// R9: Software follows channel setup order with settling
// R10: Matching result change raises request when enabled
// R11: Filtered level needs three agreeing samples
// R12: Channel shares filter, control, vector with pin
// R13: Channels fully independent and identical; an enable write sets both pending flags
// R14: Software writes zero to reserved control bits
// R15: No filter: edge from synchronized result
// R16: Result flag readable at any time
`include "cmp_edge_params.svh"
`default_nettype none
module dual_comparator_edge_irq
(
    input  wire logic        clk_sys_in,
    input  wire logic        sys_rst_in,
    input  wire logic        hsel_in,
    input  wire logic [11:0] haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic [31:0] hwdata_in,
    input  wire logic        hready_in,
    output logic      [31:0] hrdata_out,
    output logic             hreadyout_out,
    output logic             hresp_out,
    input  wire logic        chan1_compare_in,
    input  wire logic        chan3_compare_in,
    output logic             chan1_operate_out,
    output logic             chan3_operate_out,
    output logic             src1_vector_req_out,
    output logic             src3_vector_req_out,
    output logic             irq_out
);
    import cmp_edge_pkg::*;

    reg8_t       comparator_control;
    reg8_t       input_request_enable;
    reg8_t       input_filter_select;
    reg8_t       irqc1;
    reg8_t       irqc3;
    logic [1:0]  irq_status;
    logic [1:0]  irq_mask;
    logic        dp_write;
    logic [11:0] dp_addr;
    logic [4:0]  div_cnt;
    reg8_t       next_comparator_control;
    reg8_t       next_input_request_enable;
    reg8_t       next_input_filter_select;
    reg8_t       next_irqc1;
    reg8_t       next_irqc3;
    logic [1:0]  next_irq_status;
    logic [1:0]  next_irq_mask;
    logic        next_dp_write;
    logic [11:0] next_dp_addr;
    logic [4:0]  next_div_cnt;
    logic        tick_f8;
    logic        tick_f32;
    logic        res1;
    logic        res3;
    logic        edge1;
    logic        edge3;
    logic        wr_en_reg;
    logic        addr_ok;
    logic [7:0]  wbyte;
    reg8_t       rd_val;

    // Prescaler: one-cycle enables at f1/8 and f1/32
    always_comb
    begin
        next_div_cnt = div_cnt + 5'd1;
        tick_f8 = (div_cnt[2:0] == `DIV_EIGHT_COUNT);
        tick_f32 = (div_cnt == `DIV_THIRTYTWO_COUNT);
    end

    cmp_edge_channel u_chan1
    (
        .clk_sys_in    (clk_sys_in),
        .sys_rst_in    (sys_rst_in),
        .operate_in    (comparator_control[`CHAN1_OPERATE_BIT]),
        .raw_result_in (chan1_compare_in),
        .filter_in     (filter_sel_t'(input_filter_select[`SRC1_FILTER_LSB +: 2])),
        .tick_f8_in    (tick_f8),
        .tick_f32_in   (tick_f32),
        .request_on_in (input_request_enable[`SRC1_REQ_ON_BIT]),
        .both_edges_in (input_request_enable[`SRC1_EDGE_MODE_BIT]),
        .direction_in  (irqc1[`IRQC_DIRECTION_BIT]),
        .result_out    (res1),
        .edge_out      (edge1)
    );

    // Identical second instance keeps the channels independent
    cmp_edge_channel u_chan3
    (
        .clk_sys_in    (clk_sys_in),
        .sys_rst_in    (sys_rst_in),
        .operate_in    (comparator_control[`CHAN3_OPERATE_BIT]),
        .raw_result_in (chan3_compare_in),
        .filter_in     (filter_sel_t'(input_filter_select[`SRC3_FILTER_LSB +: 2])),
        .tick_f8_in    (tick_f8),
        .tick_f32_in   (tick_f32),
        .request_on_in (input_request_enable[`SRC3_REQ_ON_BIT]),
        .both_edges_in (input_request_enable[`SRC3_EDGE_MODE_BIT]),
        .direction_in  (irqc3[`IRQC_DIRECTION_BIT]),
        .result_out    (res3),
        .edge_out      (edge3)
    ); // R13

    always_comb
    begin
        addr_ok = hsel_in && hready_in && htrans_in[1];
        next_dp_write = addr_ok && hwrite_in;
        next_dp_addr = addr_ok ? haddr_in : dp_addr;
        wbyte = hwdata_in[7:0];
        next_comparator_control = comparator_control;
        next_input_request_enable = input_request_enable;
        next_input_filter_select = input_filter_select;
        next_irqc1 = irqc1;
        next_irqc3 = irqc3;
        next_irq_mask = irq_mask;
        next_irq_status = irq_status;
        wr_en_reg = dp_write && (dp_addr == (`REG_IDX_INPUT_REQUEST_ENABLE << 2));
        if (dp_write)
        begin
            case (dp_addr)
                (`REG_IDX_COMPARATOR_CONTROL << 2):
                    next_comparator_control = wbyte & 8'h11; // R1
                (`REG_IDX_INPUT_REQUEST_ENABLE << 2):
                    next_input_request_enable = wbyte & 8'hCF; // R3 R4
                (`REG_IDX_INPUT_FILTER_SELECT << 2):
                    next_input_filter_select = wbyte & 8'hCF; // R7 R8
                (`REG_IDX_IRQ_CONTROL_SRC1 << 2):
                    next_irqc1 = wbyte & 8'h1F;
                (`REG_IDX_IRQ_CONTROL_SRC3 << 2):
                    next_irqc3 = wbyte & 8'h1F;
                (`REG_IDX_IRQ_STATUS << 2):
                    next_irq_status = irq_status & ~wbyte[1:0];
                (`REG_IDX_IRQ_MASK << 2):
                    next_irq_mask = wbyte[1:0];
                default:
                    next_irq_mask = irq_mask;
            endcase
        end
        // Rewriting the enable register can itself look like an edge
        if (edge1 || wr_en_reg)
        begin
            next_irqc1[`IRQC_PENDING_BIT] = 1'b1; // R6 R10 R12
        end
        if (edge3 || wr_en_reg)
        begin
            next_irqc3[`IRQC_PENDING_BIT] = 1'b1; // R6 R10 R12
        end
        // Set wins over a same-cycle clear
        next_irq_status = next_irq_status | {edge3, edge1};
        case (dp_addr)
            (`REG_IDX_COMPARATOR_CONTROL << 2):
                rd_val = {res3, 2'b00, comparator_control[4], res1, 2'b00,
                          comparator_control[0]}; // R2 R16
            (`REG_IDX_INPUT_REQUEST_ENABLE << 2): rd_val = input_request_enable;
            (`REG_IDX_INPUT_FILTER_SELECT << 2):  rd_val = input_filter_select;
            (`REG_IDX_IRQ_CONTROL_SRC1 << 2):     rd_val = irqc1;
            (`REG_IDX_IRQ_CONTROL_SRC3 << 2):     rd_val = irqc3;
            (`REG_IDX_IRQ_STATUS << 2):           rd_val = {6'd0, irq_status};
            (`REG_IDX_IRQ_MASK << 2):             rd_val = {6'd0, irq_mask};
            default:                              rd_val = 8'h00;
        endcase
        hrdata_out = {24'h000000, rd_val};
        hreadyout_out = 1'b1;
        hresp_out = 1'b0;
        chan1_operate_out = comparator_control[`CHAN1_OPERATE_BIT];
        chan3_operate_out = comparator_control[`CHAN3_OPERATE_BIT];
        src1_vector_req_out = irqc1[`IRQC_PENDING_BIT];
        src3_vector_req_out = irqc3[`IRQC_PENDING_BIT];
        irq_out = |(irq_status & irq_mask);
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
        begin
            comparator_control <= `REG_RESET_VALUE;
            input_request_enable <= `REG_RESET_VALUE;
            input_filter_select <= `REG_RESET_VALUE;
            irqc1 <= `REG_RESET_VALUE;
            irqc3 <= `REG_RESET_VALUE;
            irq_status <= 2'b00;
            irq_mask <= 2'b00;
            dp_write <= 1'b0;
            dp_addr <= 12'h000;
            div_cnt <= 5'd0;
        end
        else
        begin
            comparator_control <= next_comparator_control;
            input_request_enable <= next_input_request_enable;
            input_filter_select <= next_input_filter_select;
            irqc1 <= next_irqc1;
            irqc3 <= next_irqc3;
            irq_status <= next_irq_status;
            irq_mask <= next_irq_mask;
            dp_write <= next_dp_write;
            dp_addr <= next_dp_addr;
            div_cnt <= next_div_cnt;
        end
    end

    property p_edge_sets_pending;
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        edge1 |=> irqc1[`IRQC_PENDING_BIT] && irq_status[0];
    endproperty
    a_edge_sets_pending: assert property (p_edge_sets_pending) // R10
        else $error("edge on channel 1 did not set pending");

    property p_enable_write_pending;
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        wr_en_reg |=> irqc3[`IRQC_PENDING_BIT];
    endproperty
    a_enable_write_pending: assert property (p_enable_write_pending) // R6
        else $error("enable write did not set pending");

    property p_reserved_zero;
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        (input_filter_select[5:4] == 2'b00) && (comparator_control[3:1] == 3'b000);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) // R8
        else $error("reserved bits held ones");

    property p_operate_write;
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        dp_write && (dp_addr == (`REG_IDX_COMPARATOR_CONTROL << 2))
            |=> comparator_control[4] == $past(hwdata_in[4]);
    endproperty
    a_operate_write: assert property (p_operate_write) // R1
        else $error("channel 3 enable not written");

    property p_f8_tick_spacing;
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        tick_f8 |=> !tick_f8 [*7] ##1 tick_f8;
    endproperty
    a_f8_tick_spacing: assert property (p_f8_tick_spacing) // R7
        else $error("f8 sampling enable spacing wrong");

    // Status set wins over a clear, so an unmasked edge must raise the line
    property p_irq_level;
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        edge1 ##1 irq_mask[0] |-> irq_out;
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("interrupt output mismatch");
endmodule
`default_nettype wire

// ==== test/cmp_analog_model.sv ====
`default_nettype none
module cmp_analog_model
(
    input  wire logic clk_sys_in,
    input  wire logic chan1_powered_in,
    input  wire logic chan3_powered_in,
    input  wire logic chan1_above_in,
    input  wire logic chan3_above_in,
    output logic      chan1_compare_out,
    output logic      chan3_compare_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic junk = 1'b0;
    // An unpowered comparator has no valid answer; toggling exposes any path that ignores enable
    always @(posedge clk_sys_in)
        junk <= ~junk;
    assign chan1_compare_out = chan1_powered_in ? chan1_above_in : junk;
    assign chan3_compare_out = chan3_powered_in ? chan3_above_in : ~junk;
endmodule
`default_nettype wire

// ==== test/dual_comparator_edge_irq_test.sv ====
`default_nettype none
module dual_comparator_edge_irq_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] A_CTRL = 12'h7E0;
    localparam logic [11:0] A_EN   = 12'h7E8;
    localparam logic [11:0] A_FILT = 12'h7F0;
    localparam logic [11:0] A_IC1  = 12'h800;
    localparam logic [11:0] A_IC3  = 12'h804;
    localparam logic [11:0] A_STAT = 12'h808;
    localparam logic [11:0] A_MASK = 12'h80C;
    logic        clk_sys_in = 1'b0;
    logic        sys_rst_in = 1'b1;
    logic        hsel       = 1'b0;
    logic [11:0] haddr      = 12'h000;
    logic [1:0]  htrans     = 2'h0;
    logic        hwrite     = 1'b0;
    logic [2:0]  hsize      = 3'h2;
    logic [31:0] hwdata     = 32'h0;
    logic        above1     = 1'b0;
    logic        above3     = 1'b0;
    wire logic   hready;
    wire logic   hresp;
    wire logic [31:0] hrdata;
    wire logic   cmp1;
    wire logic   cmp3;
    wire logic   op1;
    wire logic   op3;
    wire logic   req1;
    wire logic   req3;
    wire logic   irq;
    int          mismatches = 0;
    int          tests_run  = 0;

    always #2.5 clk_sys_in = ~clk_sys_in;

    dual_comparator_edge_irq dut
    (
        .clk_sys_in          (clk_sys_in),
        .sys_rst_in          (sys_rst_in),
        .hsel_in             (hsel),
        .haddr_in            (haddr),
        .htrans_in           (htrans),
        .hwrite_in           (hwrite),
        .hsize_in            (hsize),
        .hwdata_in           (hwdata),
        .hready_in           (hready),
        .hrdata_out          (hrdata),
        .hreadyout_out       (hready),
        .hresp_out           (hresp),
        .chan1_compare_in    (cmp1),
        .chan3_compare_in    (cmp3),
        .chan1_operate_out   (op1),
        .chan3_operate_out   (op3),
        .src1_vector_req_out (req1),
        .src3_vector_req_out (req3),
        .irq_out             (irq)
    );

    cmp_analog_model far_side
    (
        .clk_sys_in        (clk_sys_in),
        .chan1_powered_in  (op1),
        .chan3_powered_in  (op3),
        .chan1_above_in    (above1),
        .chan3_above_in    (above3),
        .chan1_compare_out (cmp1),
        .chan3_compare_out (cmp3)
    );

    task automatic results;
        if (mismatches == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys_in);
    endtask

    task automatic wait_ready;
        int n;
        n = 0;
        do
        begin
            @(posedge clk_sys_in);
            n++;
        end
        while (hready !== 1'b1 && n < 50);
        if (hready !== 1'b1)
        begin
            mismatches++;
            results;
        end
    endtask

    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge clk_sys_in);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        wait_ready;
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready;
        q = hrdata;
        hsel <= 1'b0;
    endtask

    task automatic reg_write(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic expect_reg(input string what, input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(what, q, exp);
    endtask

    task automatic set_level(input bit ch3, input logic v);
        @(posedge clk_sys_in);
        if (ch3)
            above3 <= v;
        else
            above1 <= v;
    endtask

    // Waits the whole span when no request is expected, so a late one is still caught
    task automatic expect_req(input string what, input bit ch3, input logic exp, input int span);
        logic seen;
        seen = 1'b0;
        for (int i = 0; i < span && !(seen && exp); i++)
        begin
            @(posedge clk_sys_in);
            seen = seen | (ch3 ? req3 : req1);
        end
        check(what, {31'h0, seen}, {31'h0, exp});
        if (exp && !seen)
            results;
    endtask

    task automatic clear_pending(input logic [31:0] ic1, input logic [31:0] ic3);
        reg_write(A_IC1, ic1);
        reg_write(A_IC3, ic3);
    endtask

    task automatic t_reset;
        logic [11:0] regs [7] = '{A_CTRL, A_EN, A_FILT, A_IC1, A_IC3, A_STAT, A_MASK};
        for (int i = 0; i < 7; i++)
            expect_reg("reset value", regs[i], 32'h0);
        check("outputs after reset", {28'h0, op1, op3, irq, hresp}, 32'h0);
        reg_write(12'h7F8, 32'hFF);
        expect_reg("unmapped", 12'h7F8, 32'h0);
    endtask

    task automatic t_control;
        set_level(0, 1);
        reg_write(A_CTRL, 32'h11);
        settle(20);
        check("operate outputs", {30'h0, op3, op1}, 32'h3);
        expect_reg("ch1 above", A_CTRL, 32'h19);
        set_level(0, 0);
        set_level(1, 1);
        settle(10);
        expect_reg("ch3 above", A_CTRL, 32'h91);
        reg_write(A_CTRL, 32'h10);
        set_level(0, 1);
        settle(10);
        check("ch1 off", {30'h0, op3, op1}, 32'h2);
        expect_reg("ch1 disabled", A_CTRL, 32'h90);
        reg_write(A_CTRL, 32'h00);
        settle(4);
        expect_reg("both off", A_CTRL, 32'h00);
        set_level(0, 0);
        set_level(1, 0);
    endtask

    task automatic t_fields;
        reg_write(A_EN, 32'hCF);
        expect_reg("request enable bits", A_EN, 32'hCF);
        for (int c = 0; c < 4; c++)
        begin
            reg_write(A_FILT, {24'h0, 2'(c), 2'b00, 2'(c), 2'(c)});
            expect_reg("filter fields", A_FILT, {24'h0, 2'(c), 2'b00, 2'(c), 2'(c)});
        end
        reg_write(A_FILT, 32'h0);
        reg_write(A_EN, 32'h0);
        reg_write(A_IC1, 32'h15);
        expect_reg("priority and direction", A_IC1, 32'h15);
    endtask

    task automatic t_edges;
        reg_write(A_CTRL, 32'h11);
        settle(20);
        reg_write(A_IC1, 32'h10);
        reg_write(A_EN, 32'h44);
        settle(3);
        check("pending after enable write", {30'h0, req3, req1}, 32'h3);
        clear_pending(32'h10, 32'h10);
        set_level(0, 1);
        expect_req("rising edge", 0, 1, 20);
        check("other channel quiet", {31'h0, req3}, 32'h0);
        clear_pending(32'h10, 32'h10);
        set_level(0, 0);
        expect_req("falling ignored", 0, 0, 20);
        reg_write(A_IC1, 32'h00);
        reg_write(A_EN, 32'h4C);
        clear_pending(32'h00, 32'h10);
        set_level(0, 1);
        expect_req("both edges rise", 0, 1, 20);
        clear_pending(32'h00, 32'h10);
        set_level(0, 0);
        expect_req("both edges fall", 0, 1, 20);
        reg_write(A_EN, 32'h40);
        clear_pending(32'h10, 32'h10);
        set_level(0, 1);
        expect_req("request off", 0, 0, 20);
        set_level(0, 0);
        settle(10);
    endtask

    task automatic t_filter;
        int n;
        for (int c = 1; c < 4; c++)
        begin
            n = (c == 1) ? 1 : (c == 2) ? 8 : 32;
            reg_write(A_FILT, 32'(c) << 2);
            reg_write(A_EN, 32'h44);
            clear_pending(32'h10, 32'h10);
            set_level(0, 1);
            settle(2 * n - 2);
            set_level(0, 0);
            expect_req("short pulse", 0, 0, 4 * n + 8);
            set_level(0, 1);
            expect_req("held level", 0, 1, 4 * n + 12);
            set_level(0, 0);
            settle(4 * n + 8);
        end
        reg_write(A_FILT, 32'h0);
    endtask

    task automatic t_irq;
        reg_write(A_STAT, 32'h3);
        reg_write(A_MASK, 32'h0);
        expect_reg("status cleared", A_STAT, 32'h0);
        set_level(1, 1);
        expect_req("ch3 rising", 1, 1, 20);
        expect_reg("status ch3", A_STAT, 32'h2);
        check("irq masked", {31'h0, irq}, 32'h0);
        reg_write(A_MASK, 32'h2);
        settle(3);
        check("irq unmasked", {31'h0, irq}, 32'h1);
        reg_write(A_STAT, 32'h1);
        expect_reg("status other bit", A_STAT, 32'h2);
        reg_write(A_STAT, 32'h2);
        settle(3);
        check("irq cleared", {31'h0, irq}, 32'h0);
        expect_reg("status after clear", A_STAT, 32'h0);
    endtask

    initial
    begin
        repeat (8) @(posedge clk_sys_in);
        sys_rst_in <= 1'b0;
        t_reset;
        t_control;
        t_fields;
        t_edges;
        t_filter;
        t_irq;
        results;
    end
endmodule
`default_nettype wire
